/* File: bench/sop_array_top_tb_top.sv */
`timescale 1ns/1ps
module sop_array_top_tb_top
   import sop_pkg::*;
;
   // ----------------------------------------------------------
   // Stimulus and wiring
   // ----------------------------------------------------------
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [NUM_DED-1:0] ded_in = 12'h000;
   logic [NUM_MC-1:0] drv_val = 10'h000;
   logic [NUM_MC-1:0] drv_en = 10'h000;
   sop_apb_req_type apb_req = '0;
   sop_apb_rsp_type apb_rsp;
   logic [NUM_MC-1:0] io_in;
   logic [NUM_MC-1:0] io_out;
   logic [NUM_MC-1:0] io_oe;
   int miscompares = 0;
   int check_count = 0;
   int cycle_cnt = 0;

   always #2.5 clk = ~clk;

   sop_array_top sop_array_top_inst (
      .clk(clk),
      .rst_b(rst_b),
      .ded_in(ded_in),
      .io_in(io_in),
      .apb_req(apb_req),
      .io_out(io_out),
      .io_oe(io_oe),
      .apb_rsp(apb_rsp)
   );

   sop_sys_model sop_sys_model_inst (
      .clk(clk),
      .io_out(io_out),
      .io_oe(io_oe),
      .drv_val(drv_val),
      .drv_en(drv_en),
      .io_in(io_in)
   );

   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // One APB transfer; answer taken at the edge that sees pready
   task automatic apb(input logic [11:0] a, input logic wr,
      input logic [31:0] wd, input logic [31:0] exp, input logic bad);
      int n;
      logic [31:0] rd;
      logic err;
      n = 0;
      @(posedge clk);
      apb_req.paddr <= a;
      apb_req.pwrite <= wr;
      apb_req.pwdata <= wd;
      apb_req.psel <= 1'h1;
      apb_req.penable <= 1'h0;
      @(posedge clk);
      apb_req.penable <= 1'h1;
      @(posedge clk);
      while (apb_rsp.pready !== 1'h1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, apb_rsp.pready}, 32'h0000_0001);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'h0;
      apb_req.penable <= 1'h0;
      check({31'h0, err}, {31'h0, bad});
      if (wr == 1'h0)
         check(rd, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d, 32'h0000_0000, 1'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'h0, 32'h0000_0000, e, 1'h0);
   endtask

   // Blow one product term's fuses; low word chooses literals kept
   task automatic blow(input int t, input logic [31:0] lo);
      wr(12'(8 * t), lo);
      wr(12'(8 * t + 4), 32'h0000_0FFF);
   endtask

   // Pin path takes three edges; sample between edges
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Hang guard, far above the hundred-odd cycles needed
   always @(posedge clk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 20000) begin
         miscompares++;
         results();
      end
   end

   // ----------------------------------------------------------
   // Tests
   // ----------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      settle(1);
      check(32'(io_out), 32'h0000_03FF);
      check(32'(io_oe), 32'h0000_0000);
      rd(STAT_OFS, 32'h0000_0000);
      ded_in <= 12'hA5A;
      drv_val <= 10'h2C9;
      drv_en <= 10'h3FF;
      settle(3);
      rd(PIN_OFS, 32'h002C_9A5A);
      drv_en <= 10'h000;
      ded_in <= 12'h001;
      $display("test reset and inputs done");
      // Cell 0 registered high, cell 3 combinational high
      wr(SEL_OFS, 32'h0000_00C1);
      blow(30, 32'hFFFF_FFFE);
      blow(OE_PT_BASE, 32'hFFFF_FFFF);
      blow(OE_PT_BASE + 3, 32'hFFFF_FFFF);
      rd(SEL_OFS, 32'h0000_00C1);
      rd(12'h0F0, 32'hFFFF_FFFE);
      settle(3);
      check(32'(io_oe), 32'h0000_0009);
      check(32'(io_out), 32'h0000_03FE);
      @(posedge clk);
      ded_in <= 12'h000;
      settle(3);
      check(32'(io_out), 32'h0000_03F6);
      $display("test configuration done");
      wr(PRE_OFS, 32'h0000_0001);
      drv_val <= 10'h001;
      drv_en <= 10'h001;
      settle(3);
      check(32'(io_oe), 32'h0000_0000);
      rd(STAT_OFS, 32'h0000_0001);
      check(32'(io_out), 32'h0000_03F7);
      wr(PRE_OFS, 32'h0000_0000);
      drv_en <= 10'h000;
      settle(2);
      rd(STAT_OFS, 32'h0000_0000);
      $display("test preload done");
      blow(SSET_PT, 32'hFFFF_FFFF);
      settle(2);
      rd(STAT_OFS, 32'h0000_03FF);
      check(32'(io_out), 32'h0000_0001);
      blow(ARST_PT, 32'hFFFF_FFFF);
      settle(2);
      rd(STAT_OFS, 32'h0000_0000);
      check(32'(io_out), 32'h0000_03F6);
      $display("test set and reset done");
      wr(SEC_OFS, 32'h0000_0001);
      rd(12'h000, OPEN_LO);
      rd(12'h004, OPEN_HI);
      rd(12'h0F0, OPEN_LO);
      rd(SEL_OFS, SEL_OPEN);
      apb(12'h900, 1'h0, 32'h0000_0000, 32'h0000_0000, 1'h1);
      apb(12'h802, 1'h1, 32'h0000_0001, 32'h0000_0000, 1'h1);
      $display("test security done");
      @(posedge clk);
      rst_b <= 1'h0;
      @(posedge clk);
      rst_b <= 1'h1;
      settle(1);
      check(32'(io_out), 32'h0000_03FF);
      rd(SEL_OFS, 32'h0000_0000);
      $display("test second reset done");
      results();
   end
endmodule

/* File: bench/sop_sys_model.sv */
`timescale 1ns/1ps
module sop_sys_model
   import sop_pkg::*;
(
   input wire logic clk,
   input wire logic [NUM_MC-1:0] io_out,
   input wire logic [NUM_MC-1:0] io_oe,
   input wire logic [NUM_MC-1:0] drv_val,
   input wire logic [NUM_MC-1:0] drv_en,
   output logic [NUM_MC-1:0] io_in
);
   // ----------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------
   logic [NUM_MC-1:0] float_ff = 10'h155;

   // Undriven pins toggle so a stale level never passes as valid
   always_ff @(posedge clk) begin
      float_ff <= ~float_ff;
   end

   // Device driver wins; else system drives the pin as an input
   always_comb begin
      for (int i = 0; i < NUM_MC; i++) begin
         if (io_oe[i])
            io_in[i] = io_out[i];
         else if (drv_en[i])
            io_in[i] = drv_val[i];
         else
            io_in[i] = float_ff[i];
      end
   end
endmodule

/* File: common/sop_pkg.sv */
// How it works
// - Twenty-two inputs, ten separately configured macrocells
// - Each output is OR of AND terms
// - Eight to sixteen product terms in each output's sum
// - Own product term enables each output driver
// - One shared set, one shared reset term
// - Set term loads ones at next clock
// - Reset term clears registers at once
// - Pin level follows register, or sum term when combinational, through polarity
// - Two select fuses pick feedback and polarity
// - Disabled output pin usable as an input when its cell is combinational
// - Power-up: io_out all high whatever the polarity, drivers off
// - Test preload reaches any register state
// - Security fuse hides all fuses as open
// - Power-up clear zeroes every output register
// - Preload captures pin value on clock edge
package sop_pkg;

   // ------------------------------------------------------------
   // Array shape
   // ------------------------------------------------------------
   localparam int NUM_DED = 12;
   localparam int NUM_MC = 10;
   localparam int NUM_SIG = NUM_DED + NUM_MC;
   localparam int NUM_LIT = 2 * NUM_SIG;
   localparam int MAX_PT = 16;
   localparam int OE_PT_BASE = 120;
   localparam int SSET_PT = 130;
   localparam int ARST_PT = 131;
   localparam int NUM_PT = 132;

   // Per-cell sum term base index and enable mask of the 16-term slice
   localparam logic [9:0][6:0] PT_BASE = {
      7'h70, 7'h66, 7'h5A, 7'h4C, 7'h3C,
      7'h2C, 7'h1E, 7'h12, 7'h08, 7'h00};
   localparam logic [9:0][15:0] PT_MASK = {
      16'h00FF, 16'h03FF, 16'h0FFF, 16'h3FFF, 16'hFFFF,
      16'hFFFF, 16'h3FFF, 16'h0FFF, 16'h03FF, 16'h00FF};

   // ------------------------------------------------------------
   // Register map (byte addresses), secured read values and reset value
   // ------------------------------------------------------------
   localparam logic [11:0] FUSE_LAST = 12'h41C;
   localparam logic [11:0] SEL_OFS = 12'h800;
   localparam logic [11:0] SEC_OFS = 12'h804;
   localparam logic [11:0] STAT_OFS = 12'h808;
   localparam logic [11:0] PRE_OFS = 12'h80C;
   localparam logic [11:0] PIN_OFS = 12'h810;
   localparam logic [31:0] OPEN_LO = 32'hFFFF_FFFF;
   localparam logic [31:0] OPEN_HI = 32'h0000_0FFF;
   localparam logic [31:0] SEL_OPEN = 32'h000F_FFFF;
   localparam logic [9:0] IO_OUT_RST = 10'h3FF;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic feedback_type_select_fuse;
      logic polarity_select_fuse;
   } sop_sel_type;
   typedef sop_sel_type [NUM_MC-1:0] sop_sel_arr_type;

   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
      logic psel;
      logic penable;
   } sop_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sop_apb_rsp_type;

endpackage

/* File: hdl/sop_array_top.sv */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module sop_array_top
   import sop_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [NUM_DED-1:0] ded_in,
   input wire logic [NUM_MC-1:0] io_in,
   input wire sop_apb_req_type apb_req,
   output logic [NUM_MC-1:0] io_out,
   output logic [NUM_MC-1:0] io_oe,
   output sop_apb_rsp_type apb_rsp
);

   typedef struct packed {
      logic [NUM_DED-1:0] ded_s1;
      logic [NUM_DED-1:0] ded_s2;
      logic [NUM_MC-1:0] pin_s1;
      logic [NUM_MC-1:0] pin_s2;
      sop_sel_arr_type sel;
      logic secure;
      logic [NUM_MC-1:0] pre_mask;
      logic [NUM_MC-1:0] io_out;
      logic [NUM_MC-1:0] io_oe;
      sop_apb_rsp_type rsp;
   } sop_top_state_type;

   sop_top_state_type st_ff;
   sop_top_state_type nxt_st;

   // Fuse plane: one row of literal fuses per product term
   logic [NUM_LIT-1:0] fuse_ff [NUM_PT];

   logic [NUM_SIG-1:0] sig;
   logic [NUM_LIT-1:0] lits;
   logic [NUM_PT-1:0] terms;
   logic [NUM_MC-1:0] sum;
   logic [NUM_MC-1:0] oe_term;
   logic [NUM_MC-1:0] mc_q;
   logic [NUM_MC-1:0] mc_fb;
   logic [NUM_MC-1:0] out_lvl;
   logic sset_term;
   logic areset_term;
   logic preload_any;
   logic setup;
   logic wr_acc;
   logic fuse_hit;
   logic fuse_wr;
   logic [7:0] fuse_idx;
   logic [31:0] rd_data;
   logic rd_err;

   // ------------------------------------------------------------
   // Input column: dedicated inputs then macrocell feedback
   // ------------------------------------------------------------
   // Pins are asynchronous, so the array only sees second stage
   always_comb begin
      sig = {mc_fb, st_ff.ded_s2};
   end

   // Each signal feeds a true and a complemented column
   generate
      for (genvar k = 0; k < NUM_SIG; k++) begin : g_lit
         assign lits[2*k] = sig[k];
         assign lits[2*k+1] = ~sig[k];
      end
   endgenerate

   // ------------------------------------------------------------
   // AND plane
   // ------------------------------------------------------------
   generate
      for (genvar t = 0; t < NUM_PT; t++) begin : g_pt
         sop_pterm u_pt (
            .lits_i(lits),
            .fuse_i(fuse_ff[t]),
            .term_o(terms[t])
         );
      end
   endgenerate

   // Shared control terms, one of each for the whole array
   always_comb begin
      sset_term = terms[SSET_PT];
      areset_term = terms[ARST_PT];
      preload_any = |st_ff.pre_mask;
   end

   // ------------------------------------------------------------
   // OR plane and macrocells
   // ------------------------------------------------------------
   // Fixed 16-wide slice masked to each cell's own term count
   generate
      for (genvar c = 0; c < NUM_MC; c++) begin : g_mc
         assign sum[c] = |(terms[PT_BASE[c] +: MAX_PT] & PT_MASK[c]);
         assign oe_term[c] = terms[OE_PT_BASE + c];

         sop_mcell u_mc (
            .clk(clk),
            .rst_b(rst_b),
            .areset_i(areset_term),
            .sset_i(sset_term),
            .sum_i(sum[c]),
            .sel_i(st_ff.sel[c]),
            .preload_i(st_ff.pre_mask[c]),
            .pin_i(st_ff.pin_s2[c]),
            .q_o(mc_q[c]),
            .fb_o(mc_fb[c]),
            .out_o(out_lvl[c])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   // Zero wait: data is fetched in setup, pready in first access
   always_comb begin
      setup = apb_req.psel && !apb_req.penable && !st_ff.rsp.pready;
      wr_acc = apb_req.psel && apb_req.penable && st_ff.rsp.pready &&
               apb_req.pwrite;
      fuse_hit = (apb_req.paddr <= FUSE_LAST) &&
                 (apb_req.paddr[1:0] == 2'b00);
      fuse_idx = apb_req.paddr[10:3];
      fuse_wr = wr_acc && fuse_hit;
   end

   // Read mux; a set security fuse shows every fuse as open
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      if (fuse_hit) begin
         if (st_ff.secure) begin
            rd_data = apb_req.paddr[2] ? OPEN_HI : OPEN_LO;
         end else if (apb_req.paddr[2]) begin
            rd_data = {20'h0_0000, fuse_ff[fuse_idx][43:32]};
         end else begin
            rd_data = fuse_ff[fuse_idx][31:0];
         end
      end else if (apb_req.paddr == SEL_OFS) begin
         rd_data = st_ff.secure ? SEL_OPEN : {12'h000, st_ff.sel};
      end else if (apb_req.paddr == SEC_OFS) begin
         rd_data = {31'h0000_0000, st_ff.secure};
      end else if (apb_req.paddr == STAT_OFS) begin
         rd_data = {22'h00_0000, mc_q};
      end else if (apb_req.paddr == PRE_OFS) begin
         rd_data = {22'h00_0000, st_ff.pre_mask};
      end else if (apb_req.paddr == PIN_OFS) begin
         rd_data = {10'h000, st_ff.pin_s2, st_ff.ded_s2};
      end else begin
         rd_err = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ded_s1 = ded_in;
      nxt_st.ded_s2 = st_ff.ded_s1;
      nxt_st.pin_s1 = io_in;
      nxt_st.pin_s2 = st_ff.pin_s1;
      // Pins are retimed, so combinational cells lag by one cycle
      nxt_st.io_out = out_lvl;
      // Preload needs the pins free for the tester to drive
      nxt_st.io_oe = oe_term & {NUM_MC{!preload_any}};
      nxt_st.rsp.pready = setup;
      nxt_st.rsp.pslverr = setup && rd_err;
      if (setup) begin
         nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_data;
      end
      // Fuses only blow, so select bits are ORed in
      if (wr_acc && apb_req.paddr == SEL_OFS) begin
         nxt_st.sel = st_ff.sel | sop_sel_arr_type'(apb_req.pwdata[19:0]);
      end
      if (wr_acc && apb_req.paddr == SEC_OFS) begin
         nxt_st.secure = st_ff.secure | apb_req.pwdata[0];
      end
      if (wr_acc && apb_req.paddr == PRE_OFS) begin
         nxt_st.pre_mask = apb_req.pwdata[9:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.io_out <= IO_OUT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Fuse plane programming
   // ------------------------------------------------------------
   // Blow-only: a written one stays until the next reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_PT; i++) begin
            fuse_ff[i] <= '0;
         end
      end else if (fuse_wr && apb_req.paddr[2]) begin
         fuse_ff[fuse_idx][43:32] <= fuse_ff[fuse_idx][43:32] |
                                     apb_req.pwdata[11:0];
      end else if (fuse_wr) begin
         fuse_ff[fuse_idx][31:0] <= fuse_ff[fuse_idx][31:0] |
                                    apb_req.pwdata;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign io_out = st_ff.io_out;
   assign io_oe = st_ff.io_oe;
   assign apb_rsp = st_ff.rsp;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_setup;
      apb_req.psel && !apb_req.penable && !st_ff.rsp.pready;
   endsequence

   sequence s_access;
      apb_req.psel && apb_req.penable && st_ff.rsp.pready;
   endsequence

   sequence s_sec_fuse_rd;
      st_ff.secure && fuse_hit && !apb_req.pwrite;
   endsequence

   // Setup is always answered in the first access cycle
   property p_apb_ans;
      s_setup |=> s_access or !apb_req.psel;
   endproperty
   a_apb_ans: assert property (p_apb_ans)
      else $error("apb answer not in first access cycle");

   property p_fuse_locked;
      (s_setup and s_sec_fuse_rd) |=>
         st_ff.rsp.prdata == ($past(apb_req.paddr[2]) ? OPEN_HI : OPEN_LO);
   endproperty
   a_fuse_locked: assert property (p_fuse_locked)
      else $error("secured fuse read not shown open");

   property p_sset;
      (sset_term && !areset_term && !preload_any) |=>
         (mc_q == 10'h3FF) || areset_term;
   endproperty
   a_sset: assert property (p_sset)
      else $error("set term did not load ones");

   property p_areset;
      areset_term |-> mc_q == 10'h000;
   endproperty
   a_areset: assert property (p_areset)
      else $error("reset term did not clear registers");

   property p_pwr;
      $rose(rst_b) |-> (mc_q == 10'h000) && (io_out == IO_OUT_RST) &&
                       (io_oe == 10'h000);
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("power-up state wrong");

   generate
      for (genvar c = 0; c < NUM_MC; c++) begin : g_chk
         property p_pol;
            !st_ff.sel[c].feedback_type_select_fuse |=>
               io_out[c] == ($past(st_ff.sel[c].polarity_select_fuse) ?
                             $past(mc_q[c]) : !$past(mc_q[c]));
         endproperty
         a_pol: assert property (p_pol)
            else $error("registered pin level ignores polarity");

         property p_oe;
            1'b1 |=> io_oe[c] == ($past(oe_term[c]) && !$past(preload_any));
         endproperty
         a_oe: assert property (p_oe)
            else $error("output enable not from its own term");

         property p_preload;
            (st_ff.pre_mask[c] && !areset_term) |=>
               areset_term || (mc_q[c] == $past(st_ff.pin_s2[c]));
         endproperty
         a_preload: assert property (p_preload)
            else $error("preload did not capture pin value");

         property p_pin_fb;
            st_ff.sel[c].feedback_type_select_fuse [*3] |->
               mc_fb[c] == $past(io_in[c], 2);
         endproperty
         a_pin_fb: assert property (p_pin_fb)
            else $error("pin feedback does not follow the pin");
      end
   endgenerate

endmodule

/* File: hdl/sop_mcell.sv */
`timescale 1ns/1ps
module sop_mcell
   import sop_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic areset_i,
   input wire logic sset_i,
   input wire logic sum_i,
   input wire sop_sel_type sel_i,
   input wire logic preload_i,
   input wire logic pin_i,
   output logic q_o,
   output logic fb_o,
   output logic out_o
);

   typedef struct packed {
      logic q;
   } sop_mc_state_type;

   sop_mc_state_type st_ff;
   sop_mc_state_type nxt_st;
   logic raw;

   // ------------------------------------------------------------
   // Register next value
   // ------------------------------------------------------------
   // Preload outranks set so a test can force any state
   always_comb begin
      nxt_st = st_ff;
      if (preload_i) begin
         nxt_st.q = pin_i;
      end else if (sset_i) begin
         nxt_st.q = 1'b1;
      end else begin
         nxt_st.q = sum_i;
      end
   end

   // Shared reset term clears without a clock; power-up also clears
   always_ff @(posedge clk or negedge rst_b or posedge areset_i) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else if (areset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Output and feedback selection
   // ------------------------------------------------------------
   always_comb begin
      q_o = st_ff.q;
      raw = sel_i.feedback_type_select_fuse ? sum_i : st_ff.q;
      out_o = sel_i.polarity_select_fuse ? raw : ~raw;
      fb_o = sel_i.feedback_type_select_fuse ? pin_i : st_ff.q;
   end

endmodule

/* File: hdl/sop_pterm.sv */
`timescale 1ns/1ps
module sop_pterm
   import sop_pkg::*;
(
   input wire logic [NUM_LIT-1:0] lits_i,
   input wire logic [NUM_LIT-1:0] fuse_i,
   output logic term_o
);

   // ------------------------------------------------------------
   // AND plane column
   // ------------------------------------------------------------
   // Blown fuse drops a literal; all intact gives x & ~x, so false
   always_comb begin
      term_o = &(lits_i | fuse_i);
   end

endmodule
